/* hw/csr_pkg.sv */
package csr_pkg;

	// Seven-bit own address; start bytes are 0x90 (write) and 0x91 (read).
	localparam logic [6:0] OWN_ADDR       = 7'h48;
	// Seven-bit general call address.
	localparam logic [6:0] GCALL_ADDR     = 7'h00;
	// Pointer value that acts as the reset command.
	localparam logic [7:0] PTR_RESET_CMD  = 8'hbf;
	// Command byte after a general call that resets the part.
	localparam logic [7:0] GCALL_RESET    = 8'h06;
	// Pointer value after reset and after a stop.
	localparam logic [7:0] PTR_RESET_VAL  = 8'h00;
	// Reload busy time in microseconds and the clock rate in MHz.
	localparam int         RELOAD_US      = 2000;
	localparam int         CLK_MHZ        = 100;
	localparam int         RELOAD_CYCLES  = RELOAD_US * CLK_MHZ;
	// Width of the reload counter.
	localparam int         CNT_W          = 18;

	// Decoder states, one-hot.
	typedef enum logic [5:0] {
		ST_IDLE  = 6'h01,
		ST_ADDR  = 6'h02,
		ST_PTR   = 6'h04,
		ST_DATA  = 6'h08,
		ST_GCMD  = 6'h10,
		ST_SKIP  = 6'h20
	} csr_state_type;

	// Bus events delivered from the pin front end.
	typedef struct packed {
		logic start;
		logic stop;
		logic rise;
		logic fall;
		logic sda;
	} csr_bus_ev_type;

	// Front end state.
	typedef struct packed {
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic       scl_d;
		logic       sda_d;
		csr_bus_ev_type ev;
	} csr_fe_type;

endpackage

/* hw/csr_pin_sync.sv */
`timescale 1ns/1ps
// Synchronises the bus pins and detects start, stop and clock edges.
module csr_pin_sync (
	input  wire logic                    sys_clk,
	input  wire logic                    sys_rst,
	input  wire logic                    scl_in,
	input  wire logic                    sda_in,
	output csr_pkg::csr_bus_ev_type      ev
);
	import csr_pkg::*;

	csr_fe_type s_r;   // All state of the front end.
	csr_fe_type s_nxt; // Next value of the state.

	// Shift pins through two flip-flops, then compare stage two with its delayed copy.
	always_comb begin
		s_nxt          = s_r;
		s_nxt.scl_s    = {s_r.scl_s[0], scl_in};
		s_nxt.sda_s    = {s_r.sda_s[0], sda_in};
		s_nxt.scl_d    = s_r.scl_s[1];
		s_nxt.sda_d    = s_r.sda_s[1];
		s_nxt.ev.sda   = s_r.sda_s[1];
		s_nxt.ev.rise  = s_r.scl_s[1] & ~s_r.scl_d;
		s_nxt.ev.fall  = ~s_r.scl_s[1] & s_r.scl_d;
		s_nxt.ev.start = s_r.scl_s[1] & s_r.scl_d & s_r.sda_d & ~s_r.sda_s[1];
		s_nxt.ev.stop  = s_r.scl_s[1] & s_r.scl_d & ~s_r.sda_d & s_r.sda_s[1];
	end

	// Register the state; idle bus reads as both lines high.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_r <= '{scl_s: 2'h3, sda_s: 2'h3, scl_d: 1'b1, sda_d: 1'b1, ev: '{default: 1'b0}};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign ev = s_r.ev;
endmodule // csr_pin_sync

/* hw/csr_reset_ctl.sv */
`timescale 1ns/1ps
module csr_reset_ctl #(
	parameter int RELOAD_CNT = csr_pkg::RELOAD_CYCLES // Reload busy time in cycles.
) (
	input  wire logic                 sys_clk,
	input  wire logic                 sys_rst,
	input  wire logic                 scl_in,
	input  wire logic                 sda_in,
	output logic                      sda_out,
	output logic                      sda_oe,
	output logic [7:0]                reg_ptr,
	output logic                      reg_wr,
	output logic [7:0]                reg_wdata,
	output logic                      defaults_load,
	output logic                      reload_busy
);
	import csr_pkg::*;

	// Elaboration check: the reload count must fit the counter and last at least one cycle.
	// A zero count would wrap the counter to its top value and give the longest busy window.
	if (RELOAD_CNT < 1 || RELOAD_CNT >= (1 << CNT_W)) begin : g_cnt_chk
		$error("RELOAD_CNT out of range");
	end

	// All state of the controller.
	typedef struct packed {
		csr_state_type    st;
		logic [7:0]       shreg;     // Incoming byte.
		logic [3:0]       bitcnt;    // Bits taken in current byte.
		logic             ack_slot;  // In acknowledge clock.
		logic             ack_drv;   // Driving acknowledge low.
		logic             rst_pend;  // Reset byte acknowledged, reload starts after its ack.
		logic [7:0]       ptr;       // Register pointer.
		logic             wr;        // Write pulse to the pointed register.
		logic [7:0]       wdata;     // Data that goes with the write pulse.
		logic             load;      // Default reload pulse.
		logic             busy;      // Reload window in progress.
		logic [CNT_W-1:0] cnt;       // Cycles left in the reload window.
		logic             oe;        // Pulling the data line low.
	} csr_ctl_type;

	csr_ctl_type     s_r;   // Registered state.
	csr_ctl_type     s_nxt; // Next state.
	csr_bus_ev_type  ev;    // Synchronised bus events.
	logic [7:0]      byte_in; // Byte completed on this rising edge.

	csr_pin_sync u_sync (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.scl_in  (scl_in),
		.sda_in  (sda_in),
		.ev      (ev)
	);

	// The byte as it stands with the bit of the current rising edge shifted in.
	// At the eighth rise this is the complete received byte.
	assign byte_in = {s_r.shreg[6:0], ev.sda};

	// Byte decoder, acknowledge control and reload timer.
	always_comb begin
		s_nxt      = s_r;
		s_nxt.wr   = 1'b0;
		s_nxt.load = 1'b0;
		// The pointer advances one cycle after the write pulse, so reg_ptr shows the written address.
		if (s_r.wr) begin
			s_nxt.ptr = s_r.ptr + 8'h01;
		end
		if (s_r.busy) begin
			// Reload in progress: ignore the bus except the clock fall that releases the acknowledge.
			s_nxt.st       = ST_IDLE;
			s_nxt.ack_slot = 1'b0;
			s_nxt.ack_drv  = 1'b0;
			s_nxt.rst_pend = 1'b0;
			// The acknowledge of the reset byte is let go only at the next clock fall.
			// Releasing it while the clock is high would look like a stop to other devices.
			if (ev.fall) begin
				s_nxt.oe = 1'b0;
			end
			if (s_r.cnt == '0) begin
				s_nxt.busy = 1'b0;
			end else begin
				s_nxt.cnt = s_r.cnt - 1'b1;
			end
		end else if (ev.start) begin
			// Start or repeated start begins address reception.
			s_nxt.st       = ST_ADDR;
			s_nxt.rst_pend = 1'b0;
			s_nxt.bitcnt   = 4'h0;
			s_nxt.ack_slot = 1'b0;
			s_nxt.ack_drv  = 1'b0;
			s_nxt.oe       = 1'b0;
		end else if (ev.stop) begin
			// Stop returns to idle and clears the pointer.
			s_nxt.st  = ST_IDLE;
			s_nxt.ptr = PTR_RESET_VAL;
			s_nxt.oe  = 1'b0;
			s_nxt.rst_pend = 1'b0;
			s_nxt.ack_drv = 1'b0;
		end else if (ev.fall) begin
			// Drive or release the line on the falling clock edge.
			if (s_r.ack_slot) begin
				s_nxt.oe       = s_r.ack_drv;
			end else begin
				s_nxt.oe       = 1'b0;
			end
			if (!s_r.ack_slot && s_r.bitcnt == 4'h0 && s_r.st != ST_IDLE) begin
				s_nxt.ack_drv = 1'b0;
			end
		end else if (ev.rise && s_r.st != ST_IDLE) begin
			if (s_r.ack_slot) begin
				// Acknowledge clock finished; a skipped read still gets its acknowledge released.
				s_nxt.ack_slot = 1'b0;
				s_nxt.ack_drv  = 1'b0;
				s_nxt.bitcnt   = 4'h0;
				// A reset byte was acknowledged: the reload starts now that its acknowledge is out.
				if (s_r.rst_pend) begin
					s_nxt.rst_pend = 1'b0;
					s_nxt.load     = 1'b1;
					s_nxt.busy     = 1'b1;
					s_nxt.ptr      = PTR_RESET_VAL;
					s_nxt.cnt      = CNT_W'(RELOAD_CNT - 1);
				end
			end else if (s_r.st == ST_SKIP) begin
				// Foreign address, read or unknown general call command: let the rest of the transfer pass by.
				s_nxt.st = ST_SKIP;
			end else if (s_r.bitcnt == 4'h7) begin
				s_nxt.ack_slot = 1'b1;
				s_nxt.bitcnt   = 4'h0;
				s_nxt.ack_drv  = 1'b0;
				case (s_r.st)
					ST_ADDR: begin
						if (byte_in == {OWN_ADDR, 1'b0}) begin
							s_nxt.ack_drv = 1'b1;
							s_nxt.st      = ST_PTR;
						end else if (byte_in == {OWN_ADDR, 1'b1}) begin
							// Reads are served by the register block; only ack here.
							s_nxt.ack_drv = 1'b1;
							s_nxt.st      = ST_SKIP;
						end else if (byte_in == {GCALL_ADDR, 1'b0}) begin
							s_nxt.ack_drv = 1'b1;
							s_nxt.st      = ST_GCMD;
						end else begin
							s_nxt.st = ST_SKIP;
						end
					end
					ST_PTR: begin
						s_nxt.ack_drv = 1'b1;
						if (byte_in == PTR_RESET_CMD) begin
							// Reset inside an ordinary write, no bus reset; the byte is acknowledged first.
							s_nxt.rst_pend = 1'b1;
						end else begin
							s_nxt.ptr = byte_in;
							s_nxt.st  = ST_DATA;
						end
					end
					ST_DATA: begin
						// Data goes to the pointed register, pointer advances.
						s_nxt.ack_drv = 1'b1;
						s_nxt.wr      = 1'b1;
						s_nxt.wdata   = byte_in;
						// The pointer advances one cycle later, after reg_wr has shown it.
					end
					ST_GCMD: begin
						if (byte_in == GCALL_RESET) begin
							// Acknowledge the command; the reload follows its acknowledge clock.
							s_nxt.ack_drv  = 1'b1;
							s_nxt.rst_pend = 1'b1;
						end else begin
							s_nxt.st = ST_SKIP;
						end
					end
					default: begin
						s_nxt.st = ST_IDLE;
					end
				endcase
			end else begin
				s_nxt.shreg  = byte_in;
				s_nxt.bitcnt = s_r.bitcnt + 4'h1;
			end
		end
		// Every rising clock shifts a bit in while the port listens.
		// The decoder only looks at the byte at the eighth rise, so extra shifts are harmless.
		if (ev.rise && !s_r.busy) begin
			s_nxt.shreg = byte_in;
		end
	end

	// Register the state.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_r <= '{st: ST_IDLE, shreg: 8'h00, bitcnt: 4'h0, ack_slot: 1'b0, ack_drv: 1'b0, rst_pend: 1'b0,
			         ptr: 8'h00, wr: 1'b0, wdata: 8'h00, load: 1'b0, busy: 1'b0, cnt: '0, oe: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from flip-flops, except sda_out, which is a constant.
	// The data pin is open drain: only its enable moves, the driven level is always low.
	// The register block behind this port takes reg_ptr, reg_wr and reg_wdata as they stand.
	assign sda_out       = 1'b0;
	assign sda_oe        = s_r.oe;
	assign reg_ptr       = s_r.ptr;
	assign reg_wr        = s_r.wr;
	assign reg_wdata     = s_r.wdata;
	assign defaults_load = s_r.load;
	assign reload_busy   = s_r.busy;
endmodule // csr_reset_ctl

/* tb/csr_reset_chk.sv */
`timescale 1ns/1ps
// Watches the reset command port from its pins only.
module csr_reset_chk #(
	parameter int RELOAD_CNT = csr_pkg::RELOAD_CYCLES // Reload busy time in cycles.
) (
	input wire logic       sys_clk,
	input wire logic       sys_rst,
	input wire logic       scl_in,
	input wire logic       sda_in,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	input wire logic [7:0] reg_ptr,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic       defaults_load,
	input wire logic       reload_busy
);
	import csr_pkg::*;
	int cnt_r; // Busy cycles counted so far.
	// Counts the length of each reload window.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			cnt_r <= 0;
		else
			cnt_r <= reload_busy ? cnt_r + 1 : 0;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	load_sets_busy_a: assert property (defaults_load |-> ##[0:1] reload_busy) else $error("no busy");
	load_pulse_a: assert property (defaults_load |=> !defaults_load) else $error("long load");
	busy_cause_a: assert property ($rose(reload_busy) |-> defaults_load || $past(defaults_load)) else $error("stray busy");
	busy_no_ack_a: assert property (reload_busy && !sda_oe |=> !sda_oe) else $error("ack in reload");
	busy_len_a: assert property ($fell(reload_busy) |-> cnt_r inside {[RELOAD_CNT-1:RELOAD_CNT+1]})
		else $error("reload length");
	// A pointer loaded from the bus is never the reset command; an increment after a write may reach it.
	ptr_not_cmd_a: assert property ($changed(reg_ptr) && !$past(reg_wr) |-> reg_ptr != PTR_RESET_CMD)
		else $error("cmd stored");
	ack_low_a: assert property ($changed(sda_oe) |-> !scl_in) else $error("data moved high");
	ack_stands_a: assert property ($rose(sda_oe) |=> sda_oe [*4]) else $error("short ack");
	wr_not_reset_a: assert property (reg_wr |-> !defaults_load && !reload_busy) else $error("write in reset");
	cover property (defaults_load);
	cover property ($fell(reload_busy));
	cover property ($rose(sda_oe));
endmodule // csr_reset_chk
bind csr_reset_ctl csr_reset_chk #(.RELOAD_CNT(RELOAD_CNT)) u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
	.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .reg_ptr(reg_ptr), .reg_wr(reg_wr),
	.reg_wdata(reg_wdata), .defaults_load(defaults_load), .reload_busy(reload_busy));

/* tb/csr_bus_master.sv */
`timescale 1ns/1ps
// Bus master model; byte bits change only while the bus clock is low.
module csr_bus_master (
	input  wire logic sys_clk,
	input  wire logic sda_w,
	output logic      scl,
	output logic      sda_m
);
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	// One bus clock phase, five system clocks.
	task automatic ph();
		repeat (5) @(posedge sys_clk);
	endtask
	// Start: data falls while the clock is high.
	task automatic start();
		sda_m <= 1'b1;
		ph();
		scl <= 1'b1;
		ph();
		sda_m <= 1'b0;
		ph();
		scl <= 1'b0;
		ph();
	endtask
	// Stop: data rises while the clock is high.
	task automatic stop();
		sda_m <= 1'b0;
		ph();
		scl <= 1'b1;
		ph();
		sda_m <= 1'b1;
		ph();
	endtask
	// Byte MSB first, then data released and the acknowledge sampled.
	task automatic wbyte(input logic [7:0] b, output logic a);
		for (int i = 8; i >= 0; i--) begin
			sda_m <= (i == 0) ? 1'b1 : b[i-1];
			ph();
			scl <= 1'b1;
			ph();
			a = ~sda_w;
			scl <= 1'b0;
			ph();
		end
	endtask
endmodule // csr_bus_master

/* tb/csr_reset_tb.sv */
`timescale 1ns/1ps
// Drives the reset command port through the bus master model.
module i2c_soft_reset_handler_tb_top;
	import csr_pkg::*;
	localparam int RC = 400; // Shortened reload time.
	logic       sys_clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic       scl, sda_m, sda_in, sda_oe, sda_out, reg_wr, defaults_load, reload_busy, ack;
	logic [7:0] reg_ptr, reg_wdata;
	logic [7:0] l_ptr = 8'h00, l_dat = 8'h00, n_load = 8'h00;
	int         n_mismatch = 0;
	int         n_tests = 0;
	always #5 sys_clk = ~sys_clk;
	// Open-drain data wire with a pull-up.
	assign sda_in = sda_m & ~(sda_oe & ~sda_out);
	csr_bus_master m (.sys_clk(sys_clk), .sda_w(sda_in), .scl(scl), .sda_m(sda_m));
	csr_reset_ctl #(.RELOAD_CNT(RC)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_in),
		.sda_out(sda_out), .sda_oe(sda_oe), .reg_ptr(reg_ptr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.defaults_load(defaults_load), .reload_busy(reload_busy));
	// Records reload pulses and the last register write.
	always @(posedge sys_clk) begin
		if (defaults_load)
			n_load <= n_load + 8'h01;
		if (reg_wr) begin
			l_ptr <= reg_ptr;
			l_dat <= reg_wdata;
		end
	end
	task automatic close_out();
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk_b(logic got, logic exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t bit %b", $time, got);
		end
	endtask
	task automatic chk_v(logic [7:0] got, logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t byte %h", $time, got);
		end
	endtask
	// One byte with its expected acknowledge.
	task automatic tx(logic [7:0] b, logic exp);
		m.wbyte(b, ack);
		chk_b(ack, exp);
	endtask
	// Master waits out the reload, bounded.
	task automatic wait_idle();
		for (int i = 0; i < 4 * RC && reload_busy !== 1'b0; i++) @(posedge sys_clk);
		chk_b(reload_busy, 1'b0);
		if (reload_busy !== 1'b0)
			close_out();
	endtask
	// Plain write, a read address and a foreign address.
	task automatic sc_write();
		m.start();
		tx(8'h90, 1'b1);
		tx(8'h05, 1'b1);
		tx(8'ha5, 1'b1);
		m.stop();
		chk_v(l_ptr, 8'h05);
		chk_v(l_dat, 8'ha5);
		chk_v(reg_ptr, PTR_RESET_VAL);
		chk_b(sda_out, 1'b0);
		m.start();
		tx(8'h91, 1'b1);
		m.stop();
		m.start();
		tx(8'h01, 1'b0);
		m.stop();
		chk_v(n_load, 8'h00);
	endtask
	// Reset by pointer, refusal while busy, recovery.
	task automatic sc_ptr();
		m.start();
		tx(8'h90, 1'b1);
		tx(PTR_RESET_CMD, 1'b1);
		m.stop();
		chk_v(n_load, 8'h01);
		m.start();
		tx(8'h90, 1'b0);
		m.stop();
		wait_idle();
		m.start();
		tx(8'h90, 1'b1);
		m.stop();
	endtask
	// General call with a foreign command, then the reset command.
	task automatic sc_gcall();
		m.start();
		tx(8'h00, 1'b1);
		tx(8'h07, 1'b0);
		m.stop();
		chk_v(n_load, 8'h01);
		m.start();
		tx(8'h00, 1'b1);
		tx(GCALL_RESET, 1'b1);
		m.stop();
		chk_v(n_load, 8'h02);
		chk_b(reload_busy, 1'b1);
		wait_idle();
		m.start();
		tx(8'h00, 1'b1);
		m.stop();
	endtask
	initial begin
		repeat (20) @(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		sc_write();
		sc_ptr();
		sc_gcall();
		close_out();
	end
endmodule // i2c_soft_reset_handler_tb_top
